// file: rtl/can_irq_pkg.sv
package can_irq_pkg;
    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int AW = 5;
    localparam int DW = 16;
    localparam int MBOX_N = 16;
    localparam int MBOX_W = 4;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [AW-1:0] OFS_FLAGS = 5'h00;
    localparam logic [AW-1:0] OFS_MASK = 5'h02;
    localparam logic [AW-1:0] OFS_MBOX_MASK = 5'h04;
    localparam logic [AW-1:0] OFS_STATUS = 5'h06;
    localparam logic [AW-1:0] OFS_TX_CNT = 5'h08;
    localparam logic [AW-1:0] OFS_RX_CNT = 5'h0a;
    localparam logic [AW-1:0] OFS_RX_PEND = 5'h0c;
    localparam logic [AW-1:0] OFS_RMT_PEND = 5'h0e;
    localparam logic [AW-1:0] OFS_UNREAD_OW = 5'h10;
    localparam logic [AW-1:0] OFS_CTRL = 5'h12;

    // ------------------------------------------------------------
    // Interrupt flag register bits
    // ------------------------------------------------------------
    localparam int FL_RESET = 0;
    localparam int FL_RX = 1;
    localparam int FL_REMOTE = 2;
    localparam int FL_TX_WARN = 3;
    localparam int FL_RX_WARN = 4;
    localparam int FL_PASSIVE = 5;
    localparam int FL_BUS_OFF = 6;
    localparam int FL_OVL_REC = 7;
    localparam int FL_TX_DONE = 8;
    localparam int FL_OVERWR = 9;
    localparam int FL_SLEEP_ACT = 12;
    localparam logic [DW-1:0] FLAGS_USED = 16'h13ff;
    localparam logic [DW-1:0] FLAGS_RST = 16'h0001;
    localparam logic [DW-1:0] ERR_GROUP = 16'h12fc;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DW-1:0] MASK_RST = 16'hffff;
    localparam logic [DW-1:0] MBOX_MASK_RST = 16'hffff;
    localparam logic [DW-1:0] PEND_RST = 16'h0000;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // ------------------------------------------------------------
    // Control and status bits
    // ------------------------------------------------------------
    localparam int CT_SLEEP = 0;
    localparam int CT_WAKE = 1;
    localparam int CT_XFER = 2;
    localparam int ST_BUS_OFF = 0;
    localparam int ST_WARN = 1;
    localparam int ST_PASSIVE = 2;
    localparam int ST_RESET = 3;

    // ------------------------------------------------------------
    // Fault confinement limits
    // ------------------------------------------------------------
    localparam logic [8:0] TX_WARN_LIM = 9'h060;
    localparam logic [8:0] TX_PASS_LIM = 9'h080;
    localparam logic [8:0] TX_BOFF_LIM = 9'h100;
    localparam logic [7:0] RX_WARN_LIM = 8'h60;
    localparam logic [7:0] RX_PASS_LIM = 8'h80;
    localparam logic [7:0] RX_CNT_MAX = 8'hff;
    localparam logic [7:0] RECOV_SEQ = 8'h80;
    localparam logic [3:0] RECESS_BITS = 4'hb;
endpackage : can_irq_pkg

// file: rtl/can_irq_status.sv
`timescale 1ns/1ns
module can_irq_status
    import can_irq_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic module_stop,
    input wire logic medium_speed,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic [1:0] reg_be,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    input wire logic can_rx_pin,
    input wire logic bit_tick,
    input wire logic tec_add8,
    input wire logic tec_sub1,
    input wire logic rec_add1,
    input wire logic rec_add8,
    input wire logic rec_sub1,
    input wire logic rx_done,
    input wire logic rx_remote,
    input wire logic [MBOX_W-1:0] rx_mbox,
    input wire logic tx_event,
    input wire logic [MBOX_W-1:0] tx_mbox,
    input wire logic overload_tx,
    input wire logic xfer_done,
    output logic error_group_request,
    output logic mbox0_receive_request,
    output logic other_mbox_receive_request,
    output logic tx_cancel_request,
    output logic xfer_request,
    output logic bus_off_state,
    output logic sleep_mode
);
    // ------------------------------------------------------------
    // Reset and access gating
    // ------------------------------------------------------------
    logic rst_all;
    logic access_ok;
    logic wr_ok;
    logic [DW-1:0] wmask;
    logic [AW-1:0] word_addr;

    assign rst_all = !rstn || hw_standby || sw_standby;
    assign access_ok = !module_stop && !medium_speed;
    assign wr_ok = reg_wr && access_ok;
    assign wmask = {{8{reg_be[1]}}, {8{reg_be[0]}}};
    assign word_addr = {reg_addr[AW-1:1], 1'b0};

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [DW-1:0] mask_r;
    logic [DW-1:0] mbox_mask_r;
    logic [2:0] ctrl_r;
    logic [DW-1:0] flags;
    logic [DW-1:0] rx_pend;
    logic [DW-1:0] rmt_pend;
    logic [DW-1:0] unread_ow;
    logic bus_act;

    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            mask_r <= MASK_RST;
        end else if (wr_ok && word_addr == OFS_MASK) begin
            mask_r <= (mask_r & ~wmask) | (reg_wdata & wmask);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            mbox_mask_r <= MBOX_MASK_RST;
        end else if (wr_ok && word_addr == OFS_MBOX_MASK) begin
            mbox_mask_r <= (mbox_mask_r & ~wmask) | (reg_wdata & wmask);
        end
    end

    // Bus wake clears sleep after the write so the wake is not missed
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            ctrl_r <= CTRL_RST;
        end else begin
            if (wr_ok && word_addr == OFS_CTRL && reg_be[0]) begin
                ctrl_r <= reg_wdata[2:0];
            end
            if (bus_act && ctrl_r[CT_SLEEP] && ctrl_r[CT_WAKE]) begin
                ctrl_r[CT_SLEEP] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus pin sampling
    // ------------------------------------------------------------
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic [3:0] run_cnt;
    logic seq11;

    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
        end else begin
            rx_s1 <= can_rx_pin;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
        end
    end

    // Dominant edge is the first sign of a frame
    assign bus_act = rx_s3 && !rx_s2;

    // Counts recessive bit times; a dominant bit restarts the run
    always_ff @(posedge core_clk) begin
        if (rst_all || !rx_s2) begin
            run_cnt <= 4'h0;
        end else if (bit_tick) begin
            run_cnt <= seq11 ? 4'h0 : run_cnt + 4'h1;
        end
    end
    assign seq11 = bit_tick && rx_s2 && run_cnt == RECESS_BITS - 4'h1;

    // ------------------------------------------------------------
    // Error counters
    // ------------------------------------------------------------
    logic [8:0] tec_r;
    logic [8:0] tec_nxt;
    logic [7:0] rec_r;
    logic [7:0] rec_nxt;
    logic [9:0] tec_sum;
    logic [8:0] rec_sum;
    logic bus_off;
    logic recov;

    assign bus_off = tec_r >= TX_BOFF_LIM;
    assign recov = bus_off && seq11 && rec_r == RECOV_SEQ - 8'h01;
    assign tec_sum = {1'b0, tec_r} + 10'h008;
    assign rec_sum = {1'b0, rec_r} + (rec_add8 ? 9'h008 : 9'h001);

    always_comb begin
        tec_nxt = tec_r;
        if (recov) begin
            tec_nxt = 9'h000;
        end else if (bus_off) begin
            tec_nxt = tec_r;
        end else if (tec_add8) begin
            tec_nxt = (tec_sum >= {1'b0, TX_BOFF_LIM}) ?
                TX_BOFF_LIM : tec_sum[8:0];
        end else if (tec_sub1 && tec_r != 9'h000) begin
            tec_nxt = tec_r - 9'h001;
        end
    end

    always_comb begin
        rec_nxt = rec_r;
        if (recov) begin
            rec_nxt = 8'h00;
        end else if (bus_off) begin
            if (seq11) begin
                rec_nxt = rec_r + 8'h01;
            end
        end else if (rec_add8 || rec_add1) begin
            rec_nxt = rec_sum[8] ? RX_CNT_MAX : rec_sum[7:0];
        end else if (rec_sub1 && rec_r != 8'h00) begin
            rec_nxt = rec_r - 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            tec_r <= 9'h000;
            rec_r <= 8'h00;
        end else begin
            tec_r <= tec_nxt;
            rec_r <= rec_nxt;
        end
    end

    // ------------------------------------------------------------
    // Threshold crossings
    // ------------------------------------------------------------
    logic [3:0] lvl;
    logic [3:0] lvl_q;
    logic [3:0] rise;

    assign lvl[0] = tec_r >= TX_WARN_LIM;
    assign lvl[1] = rec_r >= RX_WARN_LIM;
    assign lvl[2] = tec_r >= TX_PASS_LIM || rec_r >= RX_PASS_LIM;
    assign lvl[3] = bus_off;
    assign rise = lvl & ~lvl_q;

    // Flags fire once per crossing, not every cycle above it
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            lvl_q <= 4'h0;
        end else begin
            lvl_q <= lvl;
        end
    end

    // ------------------------------------------------------------
    // Flag sources
    // ------------------------------------------------------------
    logic [DW-1:0] rx_oh;
    logic [DW-1:0] tx_oh;
    logic rx_open;
    logic ow_hit;
    logic [DW-1:0] flag_set;
    logic [DW-1:0] flag_clr;
    logic [DW-1:0] rx_set;
    logic [DW-1:0] rmt_set;
    logic [DW-1:0] pend0_clr;

    assign rx_oh = 16'h0001 << rx_mbox;
    assign tx_oh = 16'h0001 << tx_mbox;
    assign rx_open = !mbox_mask_r[rx_mbox];
    assign ow_hit = rx_done && !rx_remote && rx_pend[rx_mbox];

    always_comb begin
        flag_set = 16'h0000;
        flag_set[FL_RX] = rx_done && !rx_remote && rx_open;
        flag_set[FL_REMOTE] = rx_done && rx_remote && rx_open;
        flag_set[FL_TX_WARN] = rise[0];
        flag_set[FL_RX_WARN] = rise[1];
        flag_set[FL_PASSIVE] = rise[2];
        flag_set[FL_BUS_OFF] = rise[3];
        flag_set[FL_OVL_REC] = overload_tx || recov;
        flag_set[FL_TX_DONE] = tx_event && !mbox_mask_r[tx_mbox];
        flag_set[FL_OVERWR] = ow_hit;
        flag_set[FL_SLEEP_ACT] = bus_act && ctrl_r[CT_SLEEP];
    end

    assign flag_clr = (wr_ok && word_addr == OFS_FLAGS) ?
        (reg_wdata & wmask & FLAGS_USED) : 16'h0000;
    assign rx_set = (rx_done && !rx_remote) ? rx_oh : 16'h0000;
    assign rmt_set = (rx_done && rx_remote) ? rx_oh : 16'h0000;
    assign pend0_clr = {15'h0000, xfer_done && ctrl_r[CT_XFER]};

    sticky_flags #(.W(DW), .RST(FLAGS_RST)) u_flags (
        .core_clk(core_clk),
        .rst_all(rst_all),
        .set(flag_set),
        .clr(flag_clr),
        .q(flags)
    );

    sticky_flags #(.W(DW), .RST(PEND_RST)) u_rx_pend (
        .core_clk(core_clk),
        .rst_all(rst_all),
        .set(rx_set),
        .clr(pend0_clr | ((wr_ok && word_addr == OFS_RX_PEND) ?
            (reg_wdata & wmask) : 16'h0000)),
        .q(rx_pend)
    );

    sticky_flags #(.W(DW), .RST(PEND_RST)) u_rmt_pend (
        .core_clk(core_clk),
        .rst_all(rst_all),
        .set(rmt_set),
        .clr(pend0_clr | ((wr_ok && word_addr == OFS_RMT_PEND) ?
            (reg_wdata & wmask) : 16'h0000)),
        .q(rmt_pend)
    );

    sticky_flags #(.W(DW), .RST(PEND_RST)) u_unread (
        .core_clk(core_clk),
        .rst_all(rst_all),
        .set(ow_hit ? rx_oh : 16'h0000),
        .clr((wr_ok && word_addr == OFS_UNREAD_OW) ?
            (reg_wdata & wmask) : 16'h0000),
        .q(unread_ow)
    );

    // ------------------------------------------------------------
    // Requests
    // ------------------------------------------------------------
    logic rx_en;
    logic mb0_pend;

    assign rx_en = flags[FL_RX] && !mask_r[FL_RX];
    assign mb0_pend = (rx_pend[0] || rmt_pend[0]) && !mbox_mask_r[0];

    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            error_group_request <= 1'b0;
            mbox0_receive_request <= 1'b0;
            other_mbox_receive_request <= 1'b0;
            tx_cancel_request <= 1'b0;
            xfer_request <= 1'b0;
            bus_off_state <= 1'b0;
            sleep_mode <= 1'b0;
        end else begin
            error_group_request <= flags[FL_RESET] ||
                |(flags & ~mask_r & ERR_GROUP);
            mbox0_receive_request <= rx_en && rx_pend[0] &&
                !mbox_mask_r[0] && !ctrl_r[CT_XFER];
            other_mbox_receive_request <= rx_en &&
                |(rx_pend[15:1] & ~mbox_mask_r[15:1]);
            tx_cancel_request <= flags[FL_TX_DONE] && !mask_r[FL_TX_DONE];
            xfer_request <= ctrl_r[CT_XFER] && mb0_pend &&
                !mask_r[FL_RX];
            bus_off_state <= bus_off;
            sleep_mode <= ctrl_r[CT_SLEEP];
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [DW-1:0] status;
    logic [DW-1:0] rd_mux;

    always_comb begin
        status = 16'h0000;
        status[ST_BUS_OFF] = bus_off;
        status[ST_WARN] = lvl[0] || lvl[1];
        status[ST_PASSIVE] = lvl[2];
        status[ST_RESET] = ctrl_r[CT_SLEEP];
    end

    always_comb begin
        unique case (word_addr)
            OFS_FLAGS: rd_mux = flags & FLAGS_USED;
            OFS_MASK: rd_mux = mask_r;
            OFS_MBOX_MASK: rd_mux = mbox_mask_r;
            OFS_STATUS: rd_mux = status;
            OFS_TX_CNT: rd_mux = {7'h00, tec_r};
            OFS_RX_CNT: rd_mux = {8'h00, rec_r};
            OFS_RX_PEND: rd_mux = rx_pend;
            OFS_RMT_PEND: rd_mux = rmt_pend;
            OFS_UNREAD_OW: rd_mux = unread_ow;
            OFS_CTRL: rd_mux = {13'h0000, ctrl_r};
            default: rd_mux = 16'h0000;
        endcase
    end

    // Data stand one cycle only; idle bus reads zero
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd && access_ok) begin
            reg_rdata <= rd_mux & wmask;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst_all);

    property p_reset_unmasked;
        flags[FL_RESET] |=> error_group_request;
    endproperty
    a_reset_unmasked: assert property (p_reset_unmasked)
        else $error("reset flag did not raise error request");

    property p_passive;
        $rose(lvl[2]) |-> ##1 flags[FL_PASSIVE];
    endproperty
    a_passive: assert property (p_passive)
        else $error("error passive flag missing");

    property p_bus_off;
        $rose(tec_r >= TX_BOFF_LIM) |=> flags[FL_BUS_OFF] && bus_off_state;
    endproperty
    a_bus_off: assert property (p_bus_off)
        else $error("bus off flag missing");

    property p_tx_warn;
        (tec_r >= TX_WARN_LIM) && !lvl_q[0] |=> flags[FL_TX_WARN];
    endproperty
    a_tx_warn: assert property (p_tx_warn)
        else $error("transmit warning flag missing");

    property p_recov;
        bus_off && seq11 && rec_r == 8'h7f |=>
            flags[FL_OVL_REC] && tec_r == 9'h000 ##1 !bus_off_state;
    endproperty
    a_recov: assert property (p_recov)
        else $error("bus off recovery not seen");

    property p_sleep_act;
        ctrl_r[CT_SLEEP] && rx_s3 && !rx_s2 |=> flags[FL_SLEEP_ACT];
    endproperty
    a_sleep_act: assert property (p_sleep_act)
        else $error("sleep bus activity flag missing");

    property p_mbox_mask;
        rx_done && mbox_mask_r[rx_mbox] && !flags[FL_RX] &&
            !flags[FL_REMOTE] |=> !flags[FL_RX] && !flags[FL_REMOTE];
    endproperty
    a_mbox_mask: assert property (p_mbox_mask)
        else $error("masked mailbox raised a flag");

    property p_xfer_clear;
        xfer_done && ctrl_r[CT_XFER] && !(rx_done && rx_mbox == 4'h0)
            |=> !rx_pend[0] && !rmt_pend[0];
    endproperty
    a_xfer_clear: assert property (p_xfer_clear)
        else $error("transfer end did not clear mailbox 0");

    property p_no_cpu;
        ctrl_r[CT_XFER] |=> !mbox0_receive_request;
    endproperty
    a_no_cpu: assert property (p_no_cpu)
        else $error("mailbox 0 request reached CPU");

    property p_sleep_status;
        reg_rd && access_ok && word_addr == OFS_STATUS && reg_be[0] &&
            ctrl_r[CT_SLEEP] |=> reg_rdata[ST_RESET];
    endproperty
    a_sleep_status: assert property (p_sleep_status)
        else $error("reset status bit clear in sleep");

    property p_blocked;
        reg_rd && !access_ok |=> reg_rdata == 16'h0000;
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("register read while access blocked");

    property p_overwrite;
        rx_done && !rx_remote && rx_pend[rx_mbox] |=>
            flags[FL_OVERWR] && unread_ow[$past(rx_mbox)];
    endproperty
    a_overwrite: assert property (p_overwrite)
        else $error("overwrite not recorded");
endmodule : can_irq_status

// file: rtl/sticky_flags.sv
`timescale 1ns/1ns
module sticky_flags #(
    parameter int W = 16,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic core_clk,
    input wire logic rst_all,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] q
);
    // Set beats clear so no event is lost
    always_ff @(posedge core_clk) begin
        if (rst_all) begin
            q <= RST;
        end else begin
            q <= (q & ~clr) | set;
        end
    end
endmodule : sticky_flags

// file: verif/can_bus_node.sv
`timescale 1ns/1ns
// ----
// Far-side bus node
// ----
module can_bus_node (
    input wire logic core_clk,
    input wire logic idle_en,
    input wire logic frame_en,
    output logic can_rx_pin,
    output logic bit_tick
);
    logic [1:0] div_r = 2'h0;
    // Bit clock runs between frames only while idle_en is set
    always @(posedge core_clk) begin
        div_r <= div_r + 2'h1;
        bit_tick <= (idle_en | frame_en) & (div_r == 2'h3);
    end
    // Released bus floats recessive
    always @(posedge core_clk) begin
        can_rx_pin <= frame_en ? div_r[1] : 1'h1;
    end
endmodule : can_bus_node

// file: verif/testbench.sv
`timescale 1ns/1ns
module testbench;
    import can_irq_pkg::*;
    // ----
    // Stimulus and wiring
    // ----
    localparam logic [9:0] TA8 = 10'h001, TS1 = 10'h002, RA1 = 10'h004;
    localparam logic [9:0] RA8 = 10'h008, RS1 = 10'h010, RXD = 10'h020;
    localparam logic [9:0] RMT = 10'h040, TXE = 10'h080, OVL = 10'h100;
    localparam logic [9:0] XD = 10'h200;
    logic core_clk = 1'h0, rstn = 1'h0, hw_standby = 1'h0, sw_standby = 1'h0;
    logic module_stop = 1'h0, medium_speed = 1'h0, reg_wr = 1'h0;
    logic reg_rd = 1'h0, idle_en = 1'h0, frame_en = 1'h0;
    logic [AW-1:0] reg_addr = 5'h00;
    logic [DW-1:0] reg_wdata = 16'h0000, reg_rdata, req;
    logic [1:0] reg_be = 2'h3;
    logic [9:0] ev = 10'h000;
    logic [MBOX_W-1:0] mbox = 4'h0;
    logic can_rx_pin, bit_tick, grp, m0, mb, tx, xf, boff, slp;
    int n_fail = 0;
    int comparisons = 0;
    assign req = {9'h000, grp, m0, mb, tx, xf, boff, slp};
    initial forever #25 core_clk = ~core_clk;
    can_bus_node u_node (.core_clk(core_clk), .idle_en(idle_en),
        .frame_en(frame_en), .can_rx_pin(can_rx_pin), .bit_tick(bit_tick));
    can_irq_status u_dut (.core_clk(core_clk), .rstn(rstn),
        .hw_standby(hw_standby), .sw_standby(sw_standby),
        .module_stop(module_stop), .medium_speed(medium_speed),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .can_rx_pin(can_rx_pin), .bit_tick(bit_tick), .tec_add8(ev[0]),
        .tec_sub1(ev[1]), .rec_add1(ev[2]), .rec_add8(ev[3]),
        .rec_sub1(ev[4]), .rx_done(ev[5]), .rx_remote(ev[6]),
        .rx_mbox(mbox), .tx_event(ev[7]), .tx_mbox(mbox),
        .overload_tx(ev[8]), .xfer_done(ev[9]), .error_group_request(grp),
        .mbox0_receive_request(m0), .other_mbox_receive_request(mb),
        .tx_cancel_request(tx), .xfer_request(xf), .bus_off_state(boff),
        .sleep_mode(slp));
    // ----
    // Shared tasks
    // ----
    task automatic results;
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    task automatic chk(input string nm, input logic [DW-1:0] s, e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cycles
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d,
                      input logic [1:0] b = 2'h3);
        reg_addr <= a;
        reg_wdata <= d;
        reg_be <= b;
        reg_wr <= 1'h1;
        @(posedge core_clk);
        reg_wr <= 1'h0;
        #1;
    endtask : wr
    // Data stands only in the cycle after the strobe edge
    task automatic rd(input string nm, input logic [AW-1:0] a,
                      input logic [DW-1:0] e);
        reg_addr <= a;
        reg_be <= 2'h3;
        reg_rd <= 1'h1;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1;
        chk(nm, reg_rdata, e);
    endtask : rd
    task automatic pulse(input logic [9:0] m, input int n);
        ev <= m;
        repeat (n) @(posedge core_clk);
        ev <= 10'h000;
        cycles(3);
    endtask : pulse
    task automatic frame;
        frame_en <= 1'h1;
        cycles(12);
        frame_en <= 1'h0;
        cycles(4);
    endtask : frame
    // ----
    // Scenarios
    // ----
    task automatic t_reset;
        rd("flags", OFS_FLAGS, 16'h0001);
        rd("mbmask", OFS_MBOX_MASK, 16'hffff);
        rd("unmapped", 5'h1e, 16'h0000);
        chk("req", req, 16'h0040);
        wr(OFS_FLAGS, 16'h0001);
        cycles(2);
        chk("req", req, 16'h0000);
        wr(OFS_MASK, 16'h0000, 2'h1);
        rd("mask", OFS_MASK, 16'hff00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_errors;
        pulse(TA8, 12);
        rd("tec", OFS_TX_CNT, 16'h0060);
        rd("flags", OFS_FLAGS, 16'h0008);
        pulse(TS1, 1);
        pulse(TA8, 5);
        rd("tec", OFS_TX_CNT, 16'h0087);
        rd("flags", OFS_FLAGS, 16'h0028);
        pulse(TA8, 16);
        rd("tec", OFS_TX_CNT, 16'h0100);
        rd("flags", OFS_FLAGS, 16'h0068);
        chk("req", req, 16'h0042);
        wr(OFS_MASK, 16'hffff);
        cycles(2);
        chk("req", req, 16'h0002);
        $display("error test done");
    endtask : t_errors
    task automatic t_recover;
        int i;
        i = 0;
        wr(OFS_FLAGS, 16'hffff);
        idle_en <= 1'h1;
        // 128 runs of 11 bits at 4 cycles a bit, with margin
        while (boff === 1'h1 && i < 8000) begin
            cycles(1);
            i++;
        end
        if (i == 8000) begin
            n_fail++;
            results;
        end
        idle_en <= 1'h0;
        cycles(3);
        rd("flags", OFS_FLAGS, 16'h0090);
        rd("tec", OFS_TX_CNT, 16'h0000);
        wr(OFS_FLAGS, 16'hffff);
        pulse(OVL, 1);
        rd("flags", OFS_FLAGS, 16'h0080);
        wr(OFS_FLAGS, 16'hffff);
        pulse(RA8, 16);
        pulse(RS1, 1);
        pulse(RA1, 1);
        rd("rec", OFS_RX_CNT, 16'h0080);
        rd("flags", OFS_FLAGS, 16'h0030);
        $display("recovery test done");
    endtask : t_recover
    task automatic t_mbox;
        wr(OFS_FLAGS, 16'hffff);
        wr(OFS_MASK, 16'h0000);
        wr(OFS_MBOX_MASK, 16'hfff6);
        mbox <= 4'h5;
        pulse(RXD, 1);
        rd("flags", OFS_FLAGS, 16'h0000);
        rd("pend", OFS_RX_PEND, 16'h0020);
        mbox <= 4'h3;
        pulse(RXD | RMT, 1);
        rd("flags", OFS_FLAGS, 16'h0004);
        pulse(RXD, 1);
        rd("flags", OFS_FLAGS, 16'h0006);
        chk("req", req, 16'h0050);
        pulse(RXD, 1);
        rd("unread", OFS_UNREAD_OW, 16'h0008);
        rd("flags", OFS_FLAGS, 16'h0206);
        pulse(TXE, 1);
        chk("req", req, 16'h0058);
        wr(OFS_CTRL, 16'h0004);
        mbox <= 4'h0;
        pulse(RXD, 1);
        chk("req", req, 16'h005c);
        pulse(XD, 1);
        rd("pend", OFS_RX_PEND, 16'h0028);
        $display("mailbox test done");
    endtask : t_mbox
    task automatic t_sleep;
        wr(OFS_FLAGS, 16'hffff);
        wr(OFS_CTRL, 16'h0001);
        rd("status", OFS_STATUS, 16'h000e);
        frame;
        rd("flags", OFS_FLAGS, 16'h1000);
        chk("req", req, 16'h0041);
        wr(OFS_CTRL, 16'h0003);
        frame;
        chk("req", req, 16'h0040);
        $display("sleep test done");
    endtask : t_sleep
    task automatic t_access;
        for (int i = 0; i < 2; i++) begin
            {medium_speed, module_stop} <= 2'h1 << i;
            wr(OFS_MASK, 16'h1234);
            rd("blocked", OFS_MASK, 16'h0000);
            {medium_speed, module_stop} <= 2'h0;
            rd("mask", OFS_MASK, 16'h0000);
        end
        $display("access test done");
    endtask : t_access
    task automatic t_standby;
        for (int i = 0; i < 2; i++) begin
            {hw_standby, sw_standby} <= 2'h1 << i;
            cycles(1);
            {hw_standby, sw_standby} <= 2'h0;
            cycles(1);
            rd("flags", OFS_FLAGS, 16'h0001);
            rd("rec", OFS_RX_CNT, 16'h0000);
            rd("mask", OFS_MASK, 16'hffff);
        end
        $display("standby test done");
    endtask : t_standby
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'h1;
        cycles(3);
        t_reset;
        t_errors;
        t_recover;
        t_mbox;
        t_sleep;
        t_access;
        t_standby;
        results;
    end
endmodule : testbench
